// *** logic/cpu_exception_end.sv ***
/*
 * cpu end: status mask and block bits, acceptance at instruction boundary,
 * saved status and pc, handler address, and an axi4-lite slave for software.
 * assumes the device end runs on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module cpu_exception_end (
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_sys_rst,
  // link to controller
  intc_link_if.cpu          link,
  // core
  input  wire logic         i_insn_boundary,
  input  wire logic [31:0]  i_pc,
  output logic              o_take,
  output logic [31:0]       o_handler_addr,
  // axi4-lite slave
  input  wire logic [7:0]   i_awaddr,
  input  wire logic         i_awvalid,
  output logic              o_awready,
  input  wire logic [31:0]  i_wdata,
  input  wire logic [3:0]   i_wstrb,
  input  wire logic         i_wvalid,
  output logic              o_wready,
  output logic [1:0]        o_bresp,
  output logic              o_bvalid,
  input  wire logic         i_bready,
  input  wire logic [7:0]   i_araddr,
  input  wire logic         i_arvalid,
  output logic              o_arready,
  output logic [31:0]       o_rdata,
  output logic [1:0]        o_rresp,
  output logic              o_rvalid,
  input  wire logic         i_rready
);
  // ****************************************
  // state
  // ****************************************
  logic [31:0] status_q, saved_stat_q, saved_pc_q, vector_q, handler_q, dev_rdata_q;
  logic        take_q, aw_q, w_q, bvalid_q, rvalid_q, dev_wr_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [1:0]  bresp_q, rresp_q, dev_sel_q;
  logic        do_take, do_write, mapped_w;

  // block bit holds off taking; mask bits are left as they are
  assign do_take = !link.request_out_pin_n && i_insn_boundary
                 && !status_q[intc_pkg::ST_BLOCK_BIT] && !take_q;
  assign do_write = aw_q && w_q && !bvalid_q;
  assign mapped_w = awaddr_q == intc_pkg::OFS_STATUS || awaddr_q == intc_pkg::OFS_VECTOR
                  || awaddr_q == intc_pkg::OFS_DEV_ACCESS;

  // ****************************************
  // exception entry
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_q     <= intc_pkg::STATUS_RESET;
      saved_stat_q <= '0;
      saved_pc_q   <= '0;
      handler_q    <= '0;
      take_q       <= 1'b0;
    end else begin
      take_q <= do_take;
      // a status write in the taking cycle is kept; the take bits override it
      if (do_write && awaddr_q == intc_pkg::OFS_STATUS) begin
        // clearing block with a raised mask opens nesting
        status_q <= {25'h0, wdata_q[6:0]};
      end
      if (do_take) begin
        saved_stat_q <= status_q;
        saved_pc_q   <= i_pc;
        status_q[intc_pkg::ST_BLOCK_BIT] <= 1'b1;
        status_q[intc_pkg::ST_PRIV_BIT]  <= 1'b1;
        status_q[intc_pkg::ST_BANK_BIT]  <= 1'b1;
        handler_q <= vector_q + intc_pkg::HANDLER_OFFSET;
      end
    end
  end

  // ****************************************
  // axi write side
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_q      <= 1'b0;
      w_q       <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= intc_pkg::RESP_OKAY;
      vector_q  <= '0;
      dev_wr_q  <= 1'b0;
      dev_sel_q <= intc_pkg::SEL_LEVEL_A;
    end else begin
      dev_wr_q <= 1'b0;
      if (i_awvalid && !aw_q) begin
        aw_q     <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (i_wvalid && !w_q) begin
        w_q     <= 1'b1;
        wdata_q <= i_wdata;
      end
      if (do_write) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= mapped_w ? intc_pkg::RESP_OKAY : intc_pkg::RESP_SLVERR;
        if (awaddr_q == intc_pkg::OFS_VECTOR) begin
          vector_q <= wdata_q;
        end
        if (awaddr_q == intc_pkg::OFS_DEV_ACCESS) begin
          // software keeps reserved bits zero; the device forces them anyway
          dev_wr_q  <= wdata_q[intc_pkg::DEV_WR_BIT];
          dev_sel_q <= wdata_q[intc_pkg::DEV_SEL_LSB +: 2];
        end
      end else if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // device read data settles two edges after a select change
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dev_rdata_q <= '0;
    end else begin
      dev_rdata_q <= {16'h0, link.lvl_rdata};
    end
  end

  // ****************************************
  // axi read side
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= intc_pkg::RESP_OKAY;
    end else if (i_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= intc_pkg::RESP_OKAY;
      unique case (i_araddr)
        intc_pkg::OFS_STATUS:     rdata_q <= status_q;
        intc_pkg::OFS_SAVED_STAT: rdata_q <= saved_stat_q;
        intc_pkg::OFS_SAVED_PC:   rdata_q <= saved_pc_q;
        intc_pkg::OFS_VECTOR:     rdata_q <= vector_q;
        intc_pkg::OFS_DEV_ACCESS: rdata_q <= dev_rdata_q;
        default: begin
          rdata_q <= '0;
          rresp_q <= intc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic [15:0] dev_wdata_q;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dev_wdata_q <= '0;
    end else if (do_write && awaddr_q == intc_pkg::OFS_DEV_ACCESS) begin
      dev_wdata_q <= wdata_q[15:0];
    end
  end

  assign link.lvl_sel          = dev_sel_q;
  assign link.lvl_wr           = dev_wr_q;
  assign link.lvl_wdata        = dev_wdata_q;
  assign link.status_mask_bits = status_q[3:0];
  assign link.accept           = take_q;
  assign o_take                = take_q;
  assign o_handler_addr        = handler_q;
  assign o_awready             = !aw_q;
  assign o_wready              = !w_q;
  assign o_bvalid              = bvalid_q;
  assign o_bresp               = bresp_q;
  assign o_arready             = !rvalid_q;
  assign o_rvalid              = rvalid_q;
  assign o_rdata               = rdata_q;
  assign o_rresp               = rresp_q;

endmodule
`default_nettype wire

// *** logic/intc_link_if.sv ***
/*
 * link between the interrupt controller and the cpu exception end.
 * assumes both ends share one clock; the bench joins the two modports.
 */
`timescale 1ns/10ps
`default_nettype none
interface intc_link_if;
  logic [1:0]                   lvl_sel;
  logic                         lvl_wr;
  logic [intc_pkg::REG_W-1:0]   lvl_wdata;
  logic [intc_pkg::REG_W-1:0]   lvl_rdata;
  logic [intc_pkg::LVL_W-1:0]   status_mask_bits;
  logic                         request_out_pin_n;
  logic                         accept;
  modport device (
    input  lvl_sel, lvl_wr, lvl_wdata, status_mask_bits, accept,
    output lvl_rdata, request_out_pin_n
  );
  modport cpu (
    output lvl_sel, lvl_wr, lvl_wdata, status_mask_bits, accept,
    input  lvl_rdata, request_out_pin_n
  );
endinterface
`default_nettype wire

// *** logic/intc_pkg.sv ***
/*
 * constants shared by both ends of the priority interrupt controller link.
 * assumes a single 100 mhz clock on both ends.
 */
`default_nettype none
package intc_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned REG_W   = 16;
  localparam int unsigned LVL_W   = 4;
  localparam int unsigned CODE_W  = 12;
  localparam int unsigned NUM_SRC = 14;
  // ****************************************
  // device register selects
  // ****************************************
  localparam logic [1:0] SEL_LEVEL_A = 2'h0;
  localparam logic [1:0] SEL_LEVEL_B = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_EVENT   = 2'h3;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int unsigned            CTRL_PIN_LEVEL_BIT = 15;
  localparam int unsigned            CTRL_EDGE_SEL_BIT  = 8;
  localparam logic [REG_W-1:0]       LEVEL_RESET        = 16'h0000;
  localparam logic                   EDGE_SEL_RESET     = 1'b0;
  localparam logic [LVL_W-1:0]       LEVEL_B_RSVD_MASK  = 4'h0;
  // each source: {register b, nibble index 3..0}, listed in default ranking order
  localparam logic [2:0] SRC_FIELD [NUM_SRC] = '{
    3'h3, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0,
    3'h5, 3'h5, 3'h5, 3'h5, 3'h7, 3'h6, 3'h6};
  localparam logic [CODE_W-1:0] CODE_BASE     = 12'h400;
  localparam logic [CODE_W-1:0] CODE_STEP     = 12'h020;
  localparam logic [CODE_W-1:0] CODE_NMI      = 12'h1c0;
  // ****************************************
  // cpu side register map (axi4-lite byte offsets)
  // ****************************************
  localparam logic [7:0]  OFS_STATUS     = 8'h00;
  localparam logic [7:0]  OFS_SAVED_STAT = 8'h04;
  localparam logic [7:0]  OFS_SAVED_PC   = 8'h08;
  localparam logic [7:0]  OFS_VECTOR     = 8'h0c;
  localparam logic [7:0]  OFS_DEV_ACCESS = 8'h10;
  localparam int unsigned ST_BLOCK_BIT   = 4;
  localparam int unsigned ST_PRIV_BIT    = 5;
  localparam int unsigned ST_BANK_BIT    = 6;
  localparam int unsigned DEV_WR_BIT     = 31;
  localparam int unsigned DEV_SEL_LSB    = 16;
  localparam logic [31:0] HANDLER_OFFSET = 32'h0000_0600;
  localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage
`default_nettype wire

// *** logic/priority_interrupt_controller.sv ***
/*
 * device end: level registers, nonmaskable pin edge detect, priority pick,
 * mask compare, request-out pin and event code register.
 * assumes peripheral requests come from logic on i_clk_sys and are held
 * until the peripheral flag is cleared; the nonmaskable pin is asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
module priority_interrupt_controller #(
  parameter int unsigned NUM_SRC = intc_pkg::NUM_SRC
) (
  // clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_sys_rst,
  // link to cpu end
  intc_link_if.device               link,
  // peripheral sources and pin
  input  wire logic [NUM_SRC-1:0]   i_src_req,
  input  wire logic                 i_nmi_pin,
  // acceptance report
  output logic                      o_nmi_taken,
  output logic [NUM_SRC-1:0]        o_src_taken
);
  // ****************************************
  // elaboration check
  // ****************************************
  if (NUM_SRC != intc_pkg::NUM_SRC) begin : g_src_check
    $error("source count must match the fixed source map");
  end

  // ****************************************
  // registers
  // ****************************************
  logic [intc_pkg::REG_W-1:0]  level_a_q;
  logic [intc_pkg::REG_W-1:0]  level_b_q;
  logic                        edge_sel_q;
  logic [intc_pkg::CODE_W-1:0] event_code_q;
  logic [intc_pkg::REG_W-1:0]  rdata_q;
  logic                        nmi_meta_q;
  logic                        nmi_sync_q;
  logic                        nmi_prev_q;
  logic                        nmi_pend_q;
  logic                        req_n_q;
  logic                        sel_nmi_q;
  logic [intc_pkg::CODE_W-1:0] sel_code_q;
  logic [NUM_SRC-1:0]          sel_onehot_q;
  logic                        nmi_taken_q;
  logic [NUM_SRC-1:0]          src_taken_q;

  // level registers survive everything but reset; standby has no path in here
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      level_a_q <= intc_pkg::LEVEL_RESET;
      level_b_q <= intc_pkg::LEVEL_RESET;
    end else if (link.lvl_wr) begin
      if (link.lvl_sel == intc_pkg::SEL_LEVEL_A) begin
        level_a_q <= link.lvl_wdata;
      end
      if (link.lvl_sel == intc_pkg::SEL_LEVEL_B) begin
        level_b_q <= {link.lvl_wdata[intc_pkg::REG_W-1:intc_pkg::LVL_W],
                      intc_pkg::LEVEL_B_RSVD_MASK};
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      edge_sel_q <= intc_pkg::EDGE_SEL_RESET;
    end else if (link.lvl_wr && link.lvl_sel == intc_pkg::SEL_CONTROL) begin
      edge_sel_q <= link.lvl_wdata[intc_pkg::CTRL_EDGE_SEL_BIT];
    end
  end

  // ****************************************
  // read port
  // ****************************************
  logic [intc_pkg::REG_W-1:0] ctrl_view;
  always_comb begin
    ctrl_view = '0;
    ctrl_view[intc_pkg::CTRL_PIN_LEVEL_BIT] = nmi_sync_q;
    ctrl_view[intc_pkg::CTRL_EDGE_SEL_BIT]  = edge_sel_q;
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= '0;
    end else begin
      unique case (link.lvl_sel)
        intc_pkg::SEL_LEVEL_A: rdata_q <= level_a_q;
        intc_pkg::SEL_LEVEL_B: rdata_q <= level_b_q;
        intc_pkg::SEL_CONTROL: rdata_q <= ctrl_view;
        intc_pkg::SEL_EVENT:   rdata_q <= {{(intc_pkg::REG_W-intc_pkg::CODE_W){1'b0}}, event_code_q};
      endcase
    end
  end

  // ****************************************
  // nonmaskable pin
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      nmi_meta_q <= 1'b0;
      nmi_sync_q <= 1'b0;
      nmi_prev_q <= 1'b0;
    end else begin
      nmi_meta_q <= i_nmi_pin;
      nmi_sync_q <= nmi_meta_q;
      nmi_prev_q <= nmi_sync_q;
    end
  end

  logic nmi_edge;
  logic nmi_clear;
  assign nmi_edge  = edge_sel_q ? (nmi_sync_q && !nmi_prev_q)
                                : (!nmi_sync_q && nmi_prev_q);
  assign nmi_clear = link.accept && !req_n_q && sel_nmi_q;

  // an edge in the clearing cycle is kept
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_q <= 1'b1;
    end else if (nmi_clear) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // ****************************************
  // priority pick
  // ****************************************
  logic [2*intc_pkg::REG_W-1:0] all_levels;
  logic [intc_pkg::LVL_W-1:0]   best_lvl;
  logic [NUM_SRC-1:0]           best_onehot;
  logic [intc_pkg::CODE_W-1:0]  best_code;
  logic [intc_pkg::LVL_W-1:0]   src_lvl;
  logic                         win;
  assign all_levels = {level_b_q, level_a_q};

  function automatic logic [intc_pkg::CODE_W-1:0] CODE_W_IDX(input int idx);
    CODE_W_IDX = intc_pkg::CODE_W'(idx);
  endfunction

  always_comb begin
    best_lvl    = '0;
    best_onehot = '0;
    best_code   = intc_pkg::CODE_BASE;
    src_lvl     = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      src_lvl = all_levels[int'(intc_pkg::SRC_FIELD[i])*intc_pkg::LVL_W +: intc_pkg::LVL_W];
      // strictly greater keeps the earlier ranked source on a tie
      if (i_src_req[i] && src_lvl != '0 && src_lvl > best_lvl) begin
        best_lvl    = src_lvl;
        best_onehot = '0;
        best_onehot[i] = 1'b1;
        best_code   = intc_pkg::CODE_BASE + intc_pkg::CODE_STEP * CODE_W_IDX(i);
      end
    end
  end

  // nonmaskable beats every level and ignores the mask
  assign win = nmi_pend_q || (best_onehot != '0 && best_lvl > link.status_mask_bits);

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      req_n_q      <= 1'b1;
      sel_nmi_q    <= 1'b0;
      sel_code_q   <= intc_pkg::CODE_BASE;
      sel_onehot_q <= '0;
    end else begin
      req_n_q      <= !win;
      sel_nmi_q    <= nmi_pend_q;
      sel_code_q   <= nmi_pend_q ? intc_pkg::CODE_NMI : best_code;
      sel_onehot_q <= nmi_pend_q ? '0 : best_onehot;
    end
  end

  // ****************************************
  // acceptance
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      event_code_q <= '0;
      nmi_taken_q  <= 1'b0;
      src_taken_q  <= '0;
    end else begin
      nmi_taken_q <= nmi_clear;
      src_taken_q <= (link.accept && !req_n_q) ? sel_onehot_q : '0;
      if (link.accept && !req_n_q) begin
        event_code_q <= sel_code_q;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.lvl_rdata         = rdata_q;
  assign link.request_out_pin_n = req_n_q;
  assign o_nmi_taken            = nmi_taken_q;
  assign o_src_taken            = src_taken_q;

endmodule
`default_nettype wire

// *** tb/intc_link_monitor.sv ***
/*
 * concurrent checks on the link between controller and cpu end.
 * assumes one clock and an active high asynchronous reset.
 */
`timescale 1ns/10ps
`default_nettype none
module intc_link_monitor (
  // clock and reset
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_sys_rst,
  // link signals
  input  wire logic [1:0]                 lvl_sel,
  input  wire logic                       lvl_wr,
  input  wire logic [intc_pkg::REG_W-1:0] lvl_wdata,
  input  wire logic [intc_pkg::REG_W-1:0] lvl_rdata,
  input  wire logic [intc_pkg::LVL_W-1:0] status_mask_bits,
  input  wire logic                       request_out_pin_n,
  input  wire logic                       accept
);
  // ****************************************
  // properties
  // ****************************************
  default clocking mon_cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  a_accept_needs_pin: assert property (accept |-> !$past(request_out_pin_n))
    else $error("accept while request pin high");
  a_accept_held_off: assert property (accept |=> !accept [*3])
    else $error("accept repeated while blocked");
  a_level_b_rsvd: assert property ($past(lvl_sel) == intc_pkg::SEL_LEVEL_B |-> lvl_rdata[3:0] == 4'h0)
    else $error("reserved nibble not zero");
  a_ctrl_rsvd_zero: assert property ($past(lvl_sel) == intc_pkg::SEL_CONTROL
    |-> lvl_rdata[14:9] == 6'h00 && lvl_rdata[7:0] == 8'h00)
    else $error("reserved control bits not zero");
  a_event_code_step: assert property ($past(lvl_sel) == intc_pkg::SEL_EVENT |-> lvl_rdata[4:0] == 5'h00)
    else $error("event code off step");
  a_level_a_rw: assert property ((lvl_wr && lvl_sel == intc_pkg::SEL_LEVEL_A)
    ##1 (!lvl_wr && lvl_sel == intc_pkg::SEL_LEVEL_A) |=> lvl_rdata == $past(lvl_wdata, 2))
    else $error("level a readback wrong");
  a_mask_kept: assert property (accept |=> $stable(status_mask_bits))
    else $error("mask changed by accept");
  a_full_mask_quiet: assert property ((status_mask_bits == 4'hf) [*3] |-> request_out_pin_n)
    else $error("request pin low under full mask");
endmodule
`default_nettype wire

// *** tb/test_priority_interrupt_controller.sv ***
/*
 * self-checking bench: both ends joined by the link, software over axi4-lite.
 * assumes the hand-over latencies; nmi is never left pending under a full mask.
 */
`timescale 1ns/10ps
`default_nettype none
module test_priority_interrupt_controller;
  // ****************************************
  // stimulus and wiring
  // ****************************************
  logic        clk_sys, sys_rst, nmi_pin, insn_boundary, nmi_taken, take;
  logic [13:0] src_req, src_taken;
  logic [31:0] pc, handler_addr, wdata, rdata;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  int          fails, check_count, cycles;
  int          fld [14] = '{28, 24, 20, 20, 16, 16, 16, 4, 4, 4, 4, 12, 8, 8};

  intc_link_if intc_link_if_i ();
  priority_interrupt_controller priority_interrupt_controller_i (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst),
    .link(intc_link_if_i.device), .i_src_req(src_req), .i_nmi_pin(nmi_pin), .o_nmi_taken(nmi_taken),
    .o_src_taken(src_taken));
  cpu_exception_end cpu_exception_end_i (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .link(intc_link_if_i.cpu),
    .i_insn_boundary(insn_boundary), .i_pc(pc), .o_take(take), .o_handler_addr(handler_addr),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready));
  intc_link_monitor intc_link_monitor_i (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst),
    .lvl_sel(intc_link_if_i.lvl_sel), .lvl_wr(intc_link_if_i.lvl_wr), .lvl_wdata(intc_link_if_i.lvl_wdata),
    .lvl_rdata(intc_link_if_i.lvl_rdata), .status_mask_bits(intc_link_if_i.status_mask_bits),
    .request_out_pin_n(intc_link_if_i.request_out_pin_n), .accept(intc_link_if_i.accept));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard, far above the fewer than 1400 cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      give_verdict();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        bready <= 1'b0;
        chk(bresp, er, "bresp");
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] exp, input string what);
    bit done;
    done = 1'b0;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        rready <= 1'b0;
        chk(rresp, er, "rresp");
        chk(rdata, exp, what);
      end
    end
  endtask
  task automatic dev_wr(input logic [1:0] sel, input logic [15:0] v);
    axi_wr(8'h10, {1'b1, 13'h0000, sel, v}, intc_pkg::RESP_OKAY);
  endtask
  task automatic dev_chk(input logic [1:0] sel, input logic [31:0] exp, input string what);
    axi_wr(8'h10, {14'h0000, sel, 16'h0000}, intc_pkg::RESP_OKAY);
    repeat (3) @(posedge clk_sys);
    axi_rd(8'h10, intc_pkg::RESP_OKAY, exp, what);
  endtask
  task automatic expect_take(input bit want, input logic [13:0] hot, input logic nmi, input logic [11:0] code);
    bit took;
    took = 1'b0;
    for (int n = 0; n < 24 && !took; n++) begin
      @(posedge clk_sys);
      took = (take === 1'b1);
    end
    chk(took, want, "take");
    if (took) begin
      @(posedge clk_sys);
      chk(src_taken, hot, "source");
      chk(nmi_taken, nmi, "nmi taken");
      dev_chk(intc_pkg::SEL_EVENT, code, "event code");
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int          lv, m, best, idx;
    bit          want, held;
    logic [31:0] lvls, vec;
    logic [13:0] req;
    sys_rst = 1'b1;
    {src_req, nmi_pin, insn_boundary, pc, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready, fails, check_count, cycles} = '0;
    nmi_pin = 1'b1;
    void'($urandom(32'h35fa));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    dev_chk(intc_pkg::SEL_LEVEL_A, 32'h0000, "level a reset");
    dev_chk(intc_pkg::SEL_LEVEL_B, 32'h0000, "level b reset");
    dev_chk(intc_pkg::SEL_CONTROL, 32'h8000, "control reset");
    axi_wr(8'h20, 32'h1234, intc_pkg::RESP_SLVERR);
    axi_rd(8'h20, intc_pkg::RESP_SLVERR, 32'h0, "unmapped");
    insn_boundary <= 1'b1;
    // nonmaskable pin, falling then rising edge select
    for (int e = 0; e < 2; e++) begin
      dev_wr(intc_pkg::SEL_CONTROL, e ? 16'h0100 : 16'h0000);
      axi_wr(8'h00, 32'h0000_000e, intc_pkg::RESP_OKAY);
      dev_chk(intc_pkg::SEL_CONTROL, e ? 32'h0100 : 32'h8000, "control");
      nmi_pin <= e[0];
      expect_take(1'b1, 14'h0, 1'b1, intc_pkg::CODE_NMI);
    end
    dev_wr(intc_pkg::SEL_CONTROL, 16'h0000);
    // priority pick against the mask, ties, level zero, full context
    for (int t = 0; t < 14; t++) begin
      axi_wr(8'h00, 32'h10, intc_pkg::RESP_OKAY);
      lvls = (t < 2) ? 32'h7777_7770 : (t == 2) ? 32'h0 : $urandom;
      lvls[3:0] = 4'h0;
      m = (t < 3) ? 0 : $urandom_range(15, 0);
      req = $urandom_range(16383, 1);
      vec = $urandom & 32'hffff_fffc;
      dev_wr(intc_pkg::SEL_LEVEL_A, lvls[31:16]);
      dev_wr(intc_pkg::SEL_LEVEL_B, lvls[15:0]);
      dev_chk(intc_pkg::SEL_LEVEL_A, lvls[31:16], "level a");
      dev_chk(intc_pkg::SEL_LEVEL_B, lvls[15:0], "level b");
      best = 0;
      idx = 0;
      for (int i = 0; i < 14; i++) begin
        lv = (lvls >> fld[i]) & 15;
        if (req[i] && lv > best) begin
          best = lv;
          idx = i;
        end
      end
      want = best > m;
      axi_wr(8'h0c, vec, intc_pkg::RESP_OKAY);
      axi_wr(8'h00, m, intc_pkg::RESP_OKAY);
      pc <= $urandom;
      insn_boundary <= 1'b0;
      src_req <= req;
      held = 1'b0;
      repeat (6) @(posedge clk_sys) held |= (take !== 1'b0);
      chk(held, 1'b0, "take off boundary");
      insn_boundary <= 1'b1;
      expect_take(want, want ? 14'h1 << idx : 14'h0, 1'b0, 12'h400 + 12'h020 * idx);
      if (want) begin
        axi_rd(8'h00, intc_pkg::RESP_OKAY, 32'h70 | m, "status");
        axi_rd(8'h04, intc_pkg::RESP_OKAY, m, "saved status");
        axi_rd(8'h08, intc_pkg::RESP_OKAY, pc, "saved pc");
        chk(handler_addr, vec + 32'h0000_0600, "handler");
        axi_rd(8'h0c, intc_pkg::RESP_OKAY, vec, "vector");
        chk(intc_link_if_i.request_out_pin_n, 1'b0, "pin under block");
        axi_wr(8'h00, 32'h7f, intc_pkg::RESP_OKAY);
        repeat (3) @(posedge clk_sys);
      end
      chk(intc_link_if_i.request_out_pin_n, 1'b1, "pin masked");
      if (want) begin
        axi_wr(8'h00, 32'h70 | m, intc_pkg::RESP_OKAY);
        repeat (3) @(posedge clk_sys);
        chk(intc_link_if_i.request_out_pin_n, 1'b0, "pin held");
      end
      src_req <= 14'h0;
      repeat (3) @(posedge clk_sys);
      chk(intc_link_if_i.request_out_pin_n, 1'b1, "pin released");
    end
    give_verdict();
  end
endmodule
`default_nettype wire
